// File: inc/aie_defines.vh
// Constants for the add instruction execute block.
// Overview of operation
// - Port self-modify reads the synchronised pin levels.
// - Writing timer zero count clears its prescaler when the prescaler is assigned.
// - Program counter change flushes next slot.
// - Lone second-word opcode executes as no_operation.
// - Literal add updates accumulator and five flags.
// - Register add sums accumulator and addressed file.
// - Destination bit picks accumulator or file register.
// - Bank bit picks access bank or bank register.
// - Extended set indexes addresses at most 95.
`ifndef AIE_DEFINES_VH
`define AIE_DEFINES_VH

// ==========================================================
// Quarter phases
`define AIE_Q1 2'h0
`define AIE_Q2 2'h1
`define AIE_Q3 2'h2
`define AIE_Q4 2'h3

// ==========================================================
// Opcode fields
`define AIE_OP_LIT 8'h0F
`define AIE_OP_REG 6'h09
`define AIE_OP_SECOND 4'hF
`define AIE_INSTR_NOP 16'h0000
`define AIE_D_BIT 9
`define AIE_A_BIT 8

// ==========================================================
// Data memory map
`define AIE_ACCESS_SPLIT 8'h80
`define AIE_ACCESS_HIGH 4'hF
`define AIE_INDEX_LIMIT 8'h5F
`define AIE_PORT_FIRST 12'hF80
`define AIE_PORT_LAST 12'hF84
`define AIE_PORT_SEL_W 3
`define AIE_TIMER0_ADDR 12'hFD6
`define AIE_PC_LOW_ADDR 12'hFF9

// ==========================================================
// Status flag positions
`define AIE_FLAG_C 0
`define AIE_FLAG_DC 1
`define AIE_FLAG_Z 2
`define AIE_FLAG_OV 3
`define AIE_FLAG_N 4

`endif

// File: verilog/aie_adder.v
// Eight-bit adder producing the five arithmetic flags.
`timescale 1ns/1ps
module aie_adder (
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  output wire [7:0] o_sum,
  output wire [4:0] o_flags
);
  wire [8:0] full;
  wire [4:0] low;
  assign full = {1'b0, i_a} + {1'b0, i_b};
  assign low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
  assign o_sum = full[7:0];
  // Sign wraps when both operands share a sign the result does not.
  assign o_flags = {full[7], (i_a[7] == i_b[7]) && (full[7] != i_a[7]),
                    (full[7:0] == 8'h00), low[4], full[8]};
endmodule // aie_adder

// File: verilog/aie_core.v
// Quarter-phased execution of the literal add and register add instructions.
`timescale 1ns/1ps
`include "aie_defines.vh"
module aie_core (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_instr_valid,
  input wire [15:0] i_instr,
  input wire i_ext_set_en,
  input wire [3:0] i_bank_select_register,
  input wire [11:0] i_index_base,
  input wire [7:0] i_mem_rdata,
  input wire [39:0] i_port_pins,
  input wire i_prescaler_assigned,
  input wire i_flush_req,
  output reg [1:0] o_quarter,
  output reg o_instr_taken,
  output reg [11:0] o_mem_addr,
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg [7:0] o_mem_wdata,
  output reg [7:0] o_accumulator,
  output reg [4:0] o_status,
  output reg o_prescaler_clr,
  output reg o_pc_write,
  output reg o_executing_nop
);

  // ==========================================================
  // Address decode helpers
  function [11:0] aie_ea;
    input [7:0] f;
    input a_bit;
    input ext;
    input [3:0] bank;
    input [11:0] base;
    begin
      if (a_bit)
        aie_ea = {bank, f};
      else if (ext && (f <= `AIE_INDEX_LIMIT))
        aie_ea = base + {4'h0, f};
      else if (f < `AIE_ACCESS_SPLIT)
        aie_ea = {4'h0, f};
      else
        aie_ea = {`AIE_ACCESS_HIGH, f};
    end
  endfunction

  function aie_is_port;
    input [11:0] addr;
    begin
      aie_is_port = (addr >= `AIE_PORT_FIRST) && (addr <= `AIE_PORT_LAST);
    end
  endfunction

  // ==========================================================
  // Pin synchroniser
  reg [39:0] pins_meta_r;
  reg [39:0] pins_sync_r;
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pins_meta_r <= 40'h0000000000;
      pins_sync_r <= 40'h0000000000;
    end
    else
    begin
      pins_meta_r <= i_port_pins;
      pins_sync_r <= pins_meta_r;
    end
  end

  // ==========================================================
  // Decode state
  reg [15:0] ir_r;
  reg is_lit_r;
  reg is_reg_r;
  reg flush_r;
  reg [7:0] operand_r;
  reg [7:0] sum_r;
  reg [4:0] flags_r;
  wire [7:0] sum_w;
  wire [4:0] flags_w;
  wire dest_file_w;
  wire [11:0] ea_w;
  wire [`AIE_PORT_SEL_W-1:0] port_sel_w;
  wire [11:0] port_off_w;
  wire [15:0] slot_instr_w;

  assign dest_file_w = ir_r[`AIE_D_BIT];
  assign ea_w = aie_ea(ir_r[7:0], ir_r[`AIE_A_BIT], i_ext_set_en,
                       i_bank_select_register, i_index_base);
  // The latched address is used, so a bank change after the read quarter cannot move the port.
  assign port_off_w = o_mem_addr - `AIE_PORT_FIRST;
  assign port_sel_w = port_off_w[`AIE_PORT_SEL_W-1:0];
  // A pending flush replaces the fetched word so the slot runs empty.
  assign slot_instr_w = (flush_r || i_flush_req) ? `AIE_INSTR_NOP : i_instr;

  aie_adder u_adder (
    .i_a(o_accumulator),
    .i_b(operand_r),
    .o_sum(sum_w),
    .o_flags(flags_w)
  );

  // ==========================================================
  // Quarter sequencer
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_quarter <= `AIE_Q1;
      o_instr_taken <= 1'b0;
      ir_r <= `AIE_INSTR_NOP;
      is_lit_r <= 1'b0;
      is_reg_r <= 1'b0;
      flush_r <= 1'b0;
      operand_r <= 8'h00;
      sum_r <= 8'h00;
      flags_r <= 5'h00;
      o_mem_addr <= 12'h000;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_wdata <= 8'h00;
      o_accumulator <= 8'h00;
      o_status <= 5'h00;
      o_prescaler_clr <= 1'b0;
      o_pc_write <= 1'b0;
      o_executing_nop <= 1'b0;
    end
    else
    begin
      o_quarter <= o_quarter + 2'h1;
      o_instr_taken <= 1'b0;
      o_mem_wr <= 1'b0;
      o_prescaler_clr <= 1'b0;
      o_pc_write <= 1'b0;
      if (i_flush_req)
        flush_r <= 1'b1;
      case (o_quarter)
        `AIE_Q1:
        begin
          // Decode. A lone second word has no add opcode and falls through as empty.
          ir_r <= slot_instr_w;
          o_instr_taken <= i_instr_valid;
          flush_r <= 1'b0;
          is_lit_r <= i_instr_valid && (slot_instr_w[15:8] == `AIE_OP_LIT);
          is_reg_r <= i_instr_valid && (slot_instr_w[15:10] == `AIE_OP_REG);
          o_executing_nop <= !i_instr_valid || flush_r || i_flush_req
                             || (slot_instr_w[15:12] == `AIE_OP_SECOND);
        end
        `AIE_Q2:
        begin
          // Operand address issued; memory answers combinationally in the next quarter and is sampled in Q3.
          if (is_lit_r)
            operand_r <= ir_r[7:0];
          else if (is_reg_r)
          begin
            o_mem_addr <= ea_w;
            o_mem_rd <= 1'b1;
          end
        end
        `AIE_Q3:
        begin
          o_mem_rd <= 1'b0;
          if (is_reg_r)
          begin
            // Self-modify of a port must see the pins, not the output latch.
            if (dest_file_w && aie_is_port(o_mem_addr))
              operand_r <= pins_sync_r[port_sel_w*8 +: 8];
            else
              operand_r <= i_mem_rdata;
          end
        end
        `AIE_Q4:
        begin
          if (is_lit_r || is_reg_r)
          begin
            sum_r <= sum_w;
            flags_r <= flags_w;
            o_status <= flags_w;
            if (is_reg_r && dest_file_w)
            begin
              o_mem_wr <= 1'b1;
              o_mem_wdata <= sum_w;
              if ((o_mem_addr == `AIE_TIMER0_ADDR) && i_prescaler_assigned)
                o_prescaler_clr <= 1'b1;
              if (o_mem_addr == `AIE_PC_LOW_ADDR)
              begin
                o_pc_write <= 1'b1;
                flush_r <= 1'b1;
              end
            end
            else
              o_accumulator <= sum_w;
          end
          is_lit_r <= 1'b0;
          is_reg_r <= 1'b0;
        end
        default:
          o_quarter <= `AIE_Q1;
      endcase
    end
  end

endmodule // aie_core

// File: test/aie_core_checker.sv
// Assertions on the ports of the add instruction execute core.
`timescale 1ns/1ps
module aie_core_checker (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_instr_valid,
  input wire [15:0] i_instr,
  input wire i_prescaler_assigned,
  input wire [1:0] o_quarter,
  input wire o_instr_taken,
  input wire [11:0] o_mem_addr,
  input wire o_mem_rd,
  input wire o_mem_wr,
  input wire o_prescaler_clr,
  input wire o_pc_write,
  input wire o_executing_nop
);
  // ==========
  // Properties
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_quarter; !$past(i_reset) |-> o_quarter == $past(o_quarter) + 2'h1; endproperty
  a_quarter: assert property (p_quarter) else $error("quarter skipped");
  property p_taken; o_quarter == 2'h0 && i_instr_valid |=> o_instr_taken; endproperty
  a_taken: assert property (p_taken) else $error("word not taken");
  property p_rd; o_instr_taken && !o_executing_nop && $past(i_instr[15:10]) == 6'h09 |=> o_mem_rd;
  endproperty
  a_rd: assert property (p_rd) else $error("no operand read");
  property p_rdq; o_mem_rd |-> o_quarter == 2'h2; endproperty
  a_rdq: assert property (p_rdq) else $error("read off phase");
  property p_wr; o_mem_wr |-> o_quarter == 2'h0 && $past(o_mem_rd, 2); endproperty
  a_wr: assert property (p_wr) else $error("write off phase");
  property p_pre; o_mem_wr && o_mem_addr == 12'hFD6 |-> o_prescaler_clr == i_prescaler_assigned;
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler clear wrong");
  property p_pc; o_mem_wr && o_mem_addr == 12'hFF9 |-> o_pc_write ##1 o_executing_nop; endproperty
  a_pc: assert property (p_pc) else $error("no flush slot");
  property p_nop; o_executing_nop |=> !o_mem_rd; endproperty
  a_nop: assert property (p_nop) else $error("flushed slot read");
  property p_second; o_instr_taken && $past(i_instr[15:12]) == 4'hF |-> o_executing_nop; endproperty
  a_second: assert property (p_second) else $error("second word ran");
  c_wr: cover property (o_mem_wr);
  c_pre: cover property (o_prescaler_clr);
  c_pc: cover property (o_pc_write);
endmodule // aie_core_checker

// File: test/aie_core_tb.sv
// Self-checking testbench for the add instruction execute core.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module aie_core_tb;
  logic i_clk_sys = 1'b0, i_reset = 1'b1, i_instr_valid = 1'b0, i_ext_set_en = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [3:0] i_bank_select_register = 4'h3;
  logic [11:0] i_index_base = 12'h200;
  logic [39:0] i_port_pins = 40'h0000000005;
  logic i_prescaler_assigned = 1'b1, i_flush_req = 1'b0;
  logic [1:0] o_quarter;
  logic o_instr_taken, o_mem_rd, o_mem_wr, o_prescaler_clr, o_pc_write, o_executing_nop;
  logic [11:0] o_mem_addr;
  logic [7:0] o_mem_wdata, o_accumulator;
  logic [4:0] o_status;
  int err_count = 0, check_count = 0, cycles = 0;
  // ==========
  // Rows: word, extended set, read data, then accumulator, status, address, write data.
  logic [57:0] rows [13] = '{
    {16'h0F7F, 1'h0, 8'h00, 8'h7F, 5'h00, 12'h000, 8'h00},
    {16'h0F01, 1'h0, 8'h00, 8'h80, 5'h1A, 12'h000, 8'h00},
    {16'h2442, 1'h0, 8'hC2, 8'h42, 5'h09, 12'h042, 8'h00},
    {16'h2710, 1'h0, 8'h01, 8'h42, 5'h00, 12'h310, 8'h43},
    {16'h245F, 1'h1, 8'h00, 8'h42, 5'h00, 12'h25F, 8'h43},
    {16'h2460, 1'h1, 8'h01, 8'h43, 5'h00, 12'h060, 8'h43},
    {16'h2490, 1'h0, 8'h01, 8'h44, 5'h00, 12'hF90, 8'h43},
    {16'h2680, 1'h0, 8'hAA, 8'h44, 5'h00, 12'hF80, 8'h49},
    {16'h26D6, 1'h0, 8'h01, 8'h44, 5'h00, 12'hFD6, 8'h45},
    {16'h26F9, 1'h0, 8'h00, 8'h44, 5'h00, 12'hFF9, 8'h44},
    {16'h0F01, 1'h0, 8'h00, 8'h44, 5'h00, 12'hFF9, 8'h44},
    {16'hF123, 1'h0, 8'h00, 8'h44, 5'h00, 12'hFF9, 8'h44},
    {16'h0FBC, 1'h0, 8'h00, 8'h00, 5'h07, 12'hFF9, 8'h44}};
  aie_core dut (.*);
  initial
  begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 400)
    begin
      err_count++;
      summarize();
    end
  end
  // Read data is held for the whole slot, since the memory is combinational.
  task automatic run(input logic [57:0] r);
    while (o_quarter !== 2'h0) @(negedge i_clk_sys);
    {i_instr, i_ext_set_en, i_mem_rdata} = r[57:33];
    i_instr_valid = 1'b1;
    @(negedge i_clk_sys);
    i_instr_valid = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    `CHK(o_accumulator, r[32:25])
    `CHK(o_status, r[24:20])
    `CHK(o_mem_addr, r[19:8])
    `CHK(o_mem_wdata, r[7:0])
    `CHK(o_mem_wr, (r[57:52] == 6'h09) && r[51])
    `CHK(o_prescaler_clr, (r[57:52] == 6'h09) && r[51] && (r[19:8] == 12'hFD6) && i_prescaler_assigned)
    `CHK(o_pc_write, (r[57:52] == 6'h09) && r[51] && (r[19:8] == 12'hFF9))
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge i_clk_sys);
    i_reset = 1'b0;
    foreach (rows[i]) run(rows[i]);
    @(negedge i_clk_sys);
    i_instr = 16'h0F01;
    i_instr_valid = 1'b1;
    @(negedge i_clk_sys);
    i_instr_valid = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    `CHK(o_accumulator, 8'h00)
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    `CHK(o_quarter, 2'h0)
    i_reset = 1'b0;
    run({16'h0F05, 1'h0, 8'h00, 8'h05, 5'h00, 12'h000, 8'h00});
    i_prescaler_assigned = 1'b0;
    run({16'h26D6, 1'h0, 8'h01, 8'h05, 5'h00, 12'hFD6, 8'h06});
    @(negedge i_clk_sys);
    i_flush_req = 1'b1;
    @(negedge i_clk_sys);
    i_flush_req = 1'b0;
    run({16'h0F01, 1'h0, 8'h00, 8'h05, 5'h00, 12'hFD6, 8'h06});
    `CHK(o_executing_nop, 1'b1)
    summarize();
  end
endmodule // aie_core_tb
bind aie_core aie_core_checker chk (.*);
